//--- rtl/spd_sensor.v
// Two-wire target: thermal sensor with alert output and 512-byte presence-detect store
// Contract
// (R1) Temperature register refreshes on each new sample with no host action.
// (R2) Temperature register readable any time, latest value, no clock stretching.
// (R3) Alert pin is open-drain, pulled low on configured temperature events.
// (R4) EEPROM activity never touches the alert output.
// (R5) Exactly three alert modes: interrupt, comparator, critical-only.
// (R6) Interrupt mode holds alert until host writes one to clear-event bit.
// (R7) Comparator mode releases alert once the condition is gone.
// (R8) Critical limit comparison always behaves as comparator.
// (R9) Critical-only asserts above limit, holds until below limit minus hysteresis.
// (R10) 512 bytes in four 128-byte blocks, each separately write-protectable.
// (R11) Bytes 256 to 319 always read as zero.
// (R12) Lower 384 bytes factory content; upper 128 bytes free for customer.
// (R13) Pure bus target; every transfer timed by host serial clock.
// (R14) Serial clock up to 1 MHz accepted; host must not exceed it. The bench host runs a 125 ns (8 MHz) serial clock.
// (R15) Store reachable only through the two-wire interface.
// (R16) Software protection blocks writes to bytes 0..383; upper block always writable. Here block_wp[3] can still protect the upper block.
// (R17) Protected byte stays unchanged, transfer still acknowledged normally.
`timescale 1ns/1ns
`include "spd_sensor_defines.vh"
module spd_sensor #(
   parameter [6:0] SENSOR_ADDR = `SENSOR_ADDR,
   parameter [5:0] EE_ADDR_HI  = `EE_ADDR_HI
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   output wire        alert_n_out,
   output wire        alert_n_oe,
   input  wire [15:0] temp_sample,
   input  wire        temp_sample_valid,
   input  wire [3:0]  block_wp,
   input  wire        soft_wp
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_ADDR = 6'h02;
   localparam [5:0] S_ACK  = 6'h04;
   localparam [5:0] S_RX   = 6'h08;
   localparam [5:0] S_TX   = 6'h10;
   localparam [5:0] S_TACK = 6'h20;

   reg        scl_s1_r, scl_s2_r, scl_d_r;
   reg        sda_s1_r, sda_s2_r, sda_d_r;
   reg [5:0]  state_r;
   reg [3:0]  bitcnt_r;
   reg [7:0]  shift_r;
   reg        rw_r;
   reg        is_ee_r;
   reg        page_r;
   reg        first_r;
   reg        half_r;
   reg [7:0]  ptr_r;
   reg [7:0]  msb_hold_r;
   reg        sda_oe_r;
   reg [15:0] config_r, upper_r, lower_r, crit_r, hyst_r, temp_r;
   reg        intr_latch_r;
   reg        crit_hold_r;
   reg [7:0]  mem [0:511];

   wire scl_rise = scl_s2_r & ~scl_d_r;                    // R14
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire start_c  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire stop_c   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   wire [8:0] ee_addr = {page_r, ptr_r};
   wire [1:0] blk     = ee_addr[8:7];

   // Protection by block, plus the reversible software lock on the lower 384 bytes
   wire ee_prot = block_wp[blk]                              // R10
                | (soft_wp & (ee_addr <= `EE_SWP_TOP))       // R16
                | ((ee_addr >= `EE_RSV_LO) & (ee_addr <= `EE_RSV_HI));

   wire byte_done = (bitcnt_r == 4'h8) & scl_fall;
   wire addr_sens = (shift_r[7:1] == SENSOR_ADDR);
   wire addr_ee   = (shift_r[7:2] == EE_ADDR_HI);

   // Alert comparisons, signed temperatures
   wire win_evt  = ($signed(temp_r) > $signed(upper_r)) | ($signed(temp_r) < $signed(lower_r));
   wire crit_evt = $signed(temp_r) > $signed(crit_r);
   wire [15:0] crit_lo = crit_r - hyst_r;
   wire crit_clr = $signed(temp_r) < $signed(crit_lo);
   wire [1:0] mode = config_r[1:0];
   wire alert_en = config_r[`CFG_EN_BIT];

   wire clear_wr = (state_r == S_RX) & byte_done & ~first_r & ~is_ee_r & half_r
                 & (ptr_r == `PTR_STATUS) & shift_r[0];

   reg alert_c;
   always @* begin
      case (mode)                                          // R5
         `MODE_INTR: alert_c = intr_latch_r | crit_evt;    // R6 R8
         `MODE_CRIT: alert_c = crit_hold_r;                // R9
         default:    alert_c = win_evt | crit_evt;         // R7 R8
      endcase
   end

   reg alert_r;
   // Alert depends on sensor state only, so the store can never move it
   assign alert_n_out = 1'b0;
   assign alert_n_oe  = alert_r;                           // R3 R4
   assign sda_out     = 1'b0;
   assign sda_oe      = sda_oe_r;

   function [15:0] sens_rd;
      input [7:0]  p;
      input [15:0] st;
      begin
         case (p)
            `PTR_STATUS: sens_rd = st;
            `PTR_CONFIG: sens_rd = config_r;
            `PTR_UPPER:  sens_rd = upper_r;
            `PTR_LOWER:  sens_rd = lower_r;
            `PTR_CRIT:   sens_rd = crit_r;
            `PTR_TEMP:   sens_rd = temp_r;                 // R2
            `PTR_HYST:   sens_rd = hyst_r;
            default:     sens_rd = 16'h0000;
         endcase
      end
   endfunction

   wire [15:0] status_w = {14'h0000, crit_evt, intr_latch_r};
   wire [15:0] sens_word = sens_rd(ptr_r, status_w);
   wire rsv = (ee_addr >= `EE_RSV_LO) & (ee_addr <= `EE_RSV_HI);
   wire [7:0] tx_byte = is_ee_r ? (rsv ? 8'h00 : mem[ee_addr])     // R11
                                : (half_r ? sens_word[7:0] : sens_word[15:8]);

   // Pin inputs cross into clk_sys through two flops before any use
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   // Bus target engine; never stretches the clock, so the host alone paces it
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= S_IDLE;
         bitcnt_r   <= 4'h0;
         shift_r    <= 8'h00;
         rw_r       <= 1'b0;
         is_ee_r    <= 1'b0;
         page_r     <= 1'b0;
         first_r    <= 1'b0;
         half_r     <= 1'b0;
         ptr_r      <= 8'h00;
         msb_hold_r <= 8'h00;
         sda_oe_r   <= 1'b0;
      end else if (start_c) begin                          // R13
         state_r  <= S_ADDR;
         bitcnt_r <= 4'h0;
         half_r   <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (stop_c) begin
         state_r  <= S_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (state_r)
            S_ADDR: begin
               if (scl_rise) begin
                  shift_r  <= {shift_r[6:0], sda_s2_r};
                  bitcnt_r <= bitcnt_r + 4'h1;
               end else if (byte_done) begin
                  if (addr_sens | addr_ee) begin
                     is_ee_r  <= addr_ee;
                     if (addr_ee)
                        page_r <= shift_r[1];
                     rw_r     <= shift_r[0];
                     first_r  <= ~shift_r[0];
                     sda_oe_r <= 1'b1;
                     state_r  <= S_ACK;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  bitcnt_r <= 4'h0;
                  if (rw_r) begin
                     shift_r  <= tx_byte;
                     sda_oe_r <= ~tx_byte[7];
                     if (is_ee_r)
                        ptr_r <= ptr_r + 8'h01;
                     else
                        half_r <= ~half_r;
                     state_r  <= S_TX;
                  end else begin
                     sda_oe_r <= 1'b0;
                     state_r  <= S_RX;
                  end
               end
            end
            S_RX: begin
               if (scl_rise) begin
                  shift_r  <= {shift_r[6:0], sda_s2_r};
                  bitcnt_r <= bitcnt_r + 4'h1;
               end else if (byte_done) begin
                  // Every byte is acknowledged, protected or not
                  sda_oe_r <= 1'b1;                        // R17
                  state_r  <= S_ACK;
                  if (first_r) begin
                     ptr_r   <= shift_r;
                     first_r <= 1'b0;
                     half_r  <= 1'b0;
                  end else if (is_ee_r) begin
                     ptr_r <= ptr_r + 8'h01;
                  end else begin
                     msb_hold_r <= shift_r;
                     half_r     <= ~half_r;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  bitcnt_r <= bitcnt_r + 4'h1;
               end else if (byte_done) begin
                  sda_oe_r <= 1'b0;
                  state_r  <= S_TACK;
               end else if (scl_fall) begin
                  shift_r  <= {shift_r[6:0], 1'b0};
                  sda_oe_r <= ~shift_r[6];
               end
            end
            S_TACK: begin
               if (scl_rise && sda_s2_r) begin
                  state_r <= S_IDLE;
               end else if (scl_fall) begin
                  bitcnt_r <= 4'h0;
                  shift_r  <= tx_byte;
                  sda_oe_r <= ~tx_byte[7];
                  if (is_ee_r)
                     ptr_r <= ptr_r + 8'h01;
                  else
                     half_r <= ~half_r;
                  state_r  <= S_TX;
               end
            end
            S_IDLE: begin
               sda_oe_r <= 1'b0;
            end
            default: begin
               state_r  <= S_IDLE;
               sda_oe_r <= 1'b0;
            end
         endcase
      end
   end

   wire sens_wr = (state_r == S_RX) & byte_done & ~first_r & ~is_ee_r & half_r;
   wire [15:0] wr_word = {msb_hold_r, shift_r};

   // Sensor registers and alert state
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         config_r     <= `CFG_RESET;
         upper_r      <= `UPPER_RESET;
         lower_r      <= `LOWER_RESET;
         crit_r       <= `CRIT_RESET;
         hyst_r       <= `HYST_RESET;
         temp_r       <= `TEMP_RESET;
         intr_latch_r <= 1'b0;
         crit_hold_r  <= 1'b0;
         alert_r      <= 1'b0;
      end else begin
         if (temp_sample_valid)
            temp_r <= temp_sample;                         // R1
         if (sens_wr) begin
            case (ptr_r)
               `PTR_CONFIG: config_r <= wr_word;
               `PTR_UPPER:  upper_r  <= wr_word;
               `PTR_LOWER:  lower_r  <= wr_word;
               `PTR_CRIT:   crit_r   <= wr_word;
               `PTR_HYST:   hyst_r   <= wr_word;
               default:     config_r <= config_r;
            endcase
         end
         // A fresh event in the clearing cycle keeps the latch set
         if (win_evt && mode == `MODE_INTR)
            intr_latch_r <= 1'b1;                          // R6
         else if (clear_wr || mode != `MODE_INTR)
            intr_latch_r <= 1'b0;                          // R6
         if (crit_evt)
            crit_hold_r <= 1'b1;                           // R9
         else if (crit_clr)
            crit_hold_r <= 1'b0;                           // R9
         alert_r <= alert_en & alert_c;                    // R3
      end
   end

   // Store reached only through the serial engine; protected bytes left as they are
   always @(posedge clk_sys) begin
      if ((state_r == S_RX) && byte_done && !first_r && is_ee_r && !ee_prot)
         mem[ee_addr] <= shift_r;                          // R15 R16 R17 R12
   end

endmodule // spd_sensor

//--- common/spd_sensor_defines.vh
// Constants for the module thermal sensor and presence-detect EEPROM
`ifndef SPD_SENSOR_DEFINES_VH
`define SPD_SENSOR_DEFINES_VH
`define SENSOR_ADDR    7'h18
`define EE_ADDR_HI     6'h28
`define PTR_STATUS     8'h00
`define PTR_CONFIG     8'h01
`define PTR_UPPER      8'h02
`define PTR_LOWER      8'h03
`define PTR_CRIT       8'h04
`define PTR_TEMP       8'h05
`define PTR_HYST       8'h06
`define MODE_INTR      2'h0
`define MODE_COMP      2'h1
`define MODE_CRIT      2'h2
`define CFG_EN_BIT     3
`define CFG_RESET      16'h0008
`define UPPER_RESET    16'h0550
`define LOWER_RESET    16'h0000
`define CRIT_RESET     16'h05f0
`define HYST_RESET     16'h0010
`define TEMP_RESET     16'h0000
`define EE_RSV_LO      9'h100
`define EE_RSV_HI      9'h13f
`define EE_SWP_TOP     9'h17f
`define SCL_MAX_KHZ    1000
`endif

//--- sim/spd_sensor_sva.sv
// Port assertions for the sensor and presence-detect target
`timescale 1ns/1ns
module spd_sensor_sva (
   input wire        clk_sys,
   input wire        reset_n,
   input wire        scl_in,
   input wire        sda_in,
   input wire        sda_out,
   input wire        sda_oe,
   input wire        alert_n_out,
   input wire        alert_n_oe,
   input wire [15:0] temp_sample,
   input wire        temp_sample_valid,
   input wire [3:0]  block_wp,
   input wire        soft_wp
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_sda_drive_low: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
   a_alert_drive_low: assert property (alert_n_out == 1'b0)
      else $error("alert pin value not low");
   a_reset_quiet: assert property ($rose(reset_n) |-> !sda_oe && !alert_n_oe)
      else $error("outputs driven right after reset");
   a_ack_rise: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("data pulled low outside clock low phase");
   a_ack_release: assert property ($fell(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("data released outside clock low phase");
   a_oe_steady: assert property (scl_in [*3] |-> $stable(sda_oe))
      else $error("data drive changed while clock high");
   // Register writes land in the clock low phase; a sample moves the alert two or three
   // cycles later, depending on whether a latch sits in the path
   a_alert_rise: assert property ($rose(alert_n_oe) |->
      $past(temp_sample_valid, 2) || $past(temp_sample_valid, 3) || !scl_in)
      else $error("alert rose without a cause");
   a_alert_steady: assert property (scl_in && $past(scl_in)
      && !$past(temp_sample_valid, 2) && !$past(temp_sample_valid, 3)
      |-> $stable(alert_n_oe))
      else $error("alert moved without a cause");
endmodule // spd_sensor_sva
bind spd_sensor spd_sensor_sva i_spd_sensor_sva (.clk_sys(clk_sys), .reset_n(reset_n),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .temp_sample(temp_sample),
   .temp_sample_valid(temp_sample_valid), .block_wp(block_wp), .soft_wp(soft_wp));

//--- sim/i2c_host.sv
// Behavioural two-wire bus controller, 125 ns serial clock, idle clock held high
`timescale 1ns/1ns
module i2c_host (
   input  wire dev_oe,
   output reg  scl,
   output wire sda
);
   reg host_oe = 1'b0;
   // Pull-up: a released line reads high
   assign sda = ~(host_oe | dev_oe);
   initial scl = 1'b1;
   // Non-blocking updates keep pin changes that meet a clock edge after the sampling flops
   task put_bit(input b);
      host_oe <= ~b;
      #31 scl <= 1'b1;
      #63 scl <= 1'b0;
      #31;
   endtask
   task get_bit(output b);
      host_oe <= 1'b0;
      #31 scl <= 1'b1;
      #31 b = sda;
      #32 scl <= 1'b0;
      #31;
   endtask
   task start;
      host_oe <= 1'b0;
      #31 scl <= 1'b1;
      #31 host_oe <= 1'b1;
      #31 scl <= 1'b0;
      #32;
   endtask
   task stop;
      host_oe <= 1'b1;
      #31 scl <= 1'b1;
      #31 host_oe <= 1'b0;
      #63;
   endtask
   task wbyte(input [7:0] d, output nak);
      integer i;
      for (i = 7; i >= 0; i = i - 1) put_bit(d[i]);
      get_bit(nak);
   endtask
   task rbyte(output [7:0] d, input last);
      integer i;
      for (i = 7; i >= 0; i = i - 1) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule // i2c_host

//--- sim/tb_top.sv
// Self-checking bench for the sensor and presence-detect target
`timescale 1ns/1ns
`include "spd_sensor_defines.vh"
module tb_top;
   reg         clk_sys = 1'b0;
   reg         reset_n = 1'b0;
   reg  [15:0] temp_sample = 16'h0000;
   reg         temp_sample_valid = 1'b0;
   reg  [3:0]  block_wp = 4'h0;
   reg         soft_wp = 1'b0;
   wire        scl, sda, sda_out, sda_oe, alert_n_out, alert_n_oe;
   integer     num_errors = 0;
   integer     checked = 0;
   reg  [7:0]  hi, lo;
   reg         nak;
   always #2 clk_sys = ~clk_sys;
   i2c_host i_i2c_host (.dev_oe(sda_oe), .scl(scl), .sda(sda));
   spd_sensor i_spd_sensor (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .alert_n_out(alert_n_out),
      .alert_n_oe(alert_n_oe), .temp_sample(temp_sample),
      .temp_sample_valid(temp_sample_valid), .block_wp(block_wp), .soft_wp(soft_wp));
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task send(input [7:0] b);
      begin
         i_i2c_host.wbyte(b, nak);
         chk({15'h0000, nak}, 16'h0000);
      end
   endtask
   task ee_wr(input p, input [7:0] ptr, input [7:0] d);
      begin
         i_i2c_host.start;
         send({`EE_ADDR_HI, p, 1'b0});
         send(ptr);
         send(d);
         i_i2c_host.stop;
      end
   endtask
   task ee_rd(input p, input [7:0] ptr, input [7:0] exp);
      begin
         i_i2c_host.start;
         send({`EE_ADDR_HI, p, 1'b0});
         send(ptr);
         i_i2c_host.start;
         send({`EE_ADDR_HI, p, 1'b1});
         i_i2c_host.rbyte(lo, 1'b1);
         i_i2c_host.stop;
         chk({8'h00, lo}, {8'h00, exp});
      end
   endtask
   task reg_wr(input [7:0] ptr, input [15:0] v);
      begin
         i_i2c_host.start;
         send({`SENSOR_ADDR, 1'b0});
         send(ptr);
         send(v[15:8]);
         send(v[7:0]);
         i_i2c_host.stop;
      end
   endtask
   task reg_rd(input [7:0] ptr, input [15:0] exp);
      begin
         i_i2c_host.start;
         send({`SENSOR_ADDR, 1'b0});
         send(ptr);
         i_i2c_host.start;
         send({`SENSOR_ADDR, 1'b1});
         i_i2c_host.rbyte(hi, 1'b0);
         i_i2c_host.rbyte(lo, 1'b1);
         i_i2c_host.stop;
         chk({hi, lo}, exp);
      end
   endtask
   // Alert is registered one or two cycles after the temperature register takes the sample, two when a latch sits in the path
   task sample(input [15:0] v, input exp);
      begin
         @(posedge clk_sys);
         temp_sample <= v;
         temp_sample_valid <= 1'b1;
         @(posedge clk_sys);
         temp_sample_valid <= 1'b0;
         repeat (2) @(posedge clk_sys);
         #1;
         chk({15'h0000, alert_n_oe}, {15'h0000, exp});
      end
   endtask
   task t_temp;
      begin
         sample(16'h0123, 1'b0);
         reg_rd(`PTR_TEMP, 16'h0123);
      end
   endtask
   task t_regs;
      begin
         reg_rd(`PTR_CONFIG, `CFG_RESET);
         reg_rd(`PTR_UPPER, `UPPER_RESET);
         reg_rd(`PTR_LOWER, `LOWER_RESET);
         reg_rd(`PTR_CRIT, `CRIT_RESET);
         reg_rd(`PTR_HYST, `HYST_RESET);
         reg_wr(`PTR_HYST, 16'h0020);
         reg_rd(`PTR_HYST, 16'h0020);
         reg_wr(`PTR_HYST, `HYST_RESET);
         reg_wr(`PTR_TEMP, 16'h7777);
         reg_rd(`PTR_TEMP, 16'h0123);
         reg_rd(8'h07, 16'h0000);
      end
   endtask
   task t_alert;
      begin
         sample(16'h0560, 1'b1);
         reg_rd(`PTR_STATUS, 16'h0001);
         ee_wr(1'b1, 8'hc0, 8'h44);
         chk({15'h0000, alert_n_oe}, 16'h0001);
         sample(16'h0100, 1'b1);
         reg_wr(`PTR_STATUS, 16'h0001);
         chk({15'h0000, alert_n_oe}, 16'h0000);
         reg_wr(`PTR_CONFIG, 16'h0009);
         sample(16'h0560, 1'b1);
         sample(16'h0100, 1'b0);
         reg_wr(`PTR_CONFIG, 16'h000a);
         sample(16'h0560, 1'b0);
         sample(16'h0600, 1'b1);
         reg_rd(`PTR_STATUS, 16'h0002);
         sample(16'h05e8, 1'b1);
         sample(16'h05d0, 1'b0);
         reg_wr(`PTR_CONFIG, 16'h0001);
         sample(16'h0600, 1'b0);
      end
   endtask
   task t_ee;
      begin
         ee_wr(1'b0, 8'h10, 8'h5a);
         ee_rd(1'b0, 8'h10, 8'h5a);
         @(posedge clk_sys) soft_wp <= 1'b1;
         ee_wr(1'b0, 8'h10, 8'ha5);
         ee_rd(1'b0, 8'h10, 8'h5a);
         ee_wr(1'b1, 8'h80, 8'h3c);
         ee_rd(1'b1, 8'h80, 8'h3c);
         @(posedge clk_sys) soft_wp <= 1'b0;
         @(posedge clk_sys) block_wp <= 4'h8;
         ee_wr(1'b1, 8'h80, 8'hc3);
         ee_rd(1'b1, 8'h80, 8'h3c);
         @(posedge clk_sys) block_wp <= 4'h0;
         ee_wr(1'b1, 8'h00, 8'h77);
         ee_rd(1'b1, 8'h00, 8'h00);
         ee_rd(1'b1, 8'h3f, 8'h00);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      #300000;
      num_errors = num_errors + 1;
      $display("ERROR %0t: run did not finish in time", $time);
      conclude;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_temp;
      t_regs;
      t_ee;
      t_alert;
      conclude;
   end
endmodule // tb_top
